// ### rtl/fiw_ctrl.sv
// Controller that unlocks, erases, programs and verifies one flash page
`timescale 1ns/1ps
module fiw_ctrl (
  // Clock and reset
  input  wire logic                 clk_i,
  input  wire logic                 reset_n_i,
  // User command
  input  wire logic                 cmd_valid_i,
  input  wire fiw_pkg::fiw_cmd_type cmd_code_i,
  input  wire logic [8:0]           cmd_page_i,
  input  wire logic [6:0]           cmd_count_i,
  output logic                      cmd_ready_o,
  output logic                      done_o,
  output logic                      fail_o,
  output logic                      enabled_o,
  // Page data load
  input  wire logic                 load_we_i,
  input  wire logic [5:0]           load_idx_i,
  input  wire logic [15:0]          load_data_i,
  // Device registers
  output logic [3:0]                dev_addr_o,
  output logic [7:0]                dev_wdata_o,
  output logic                      dev_wr_o,
  output logic                      dev_rd_o,
  input  wire logic [7:0]           dev_rdata_i,
  input  wire logic                 dev_ack_i,
  // Flash table read
  output logic                      tr_req_o,
  output logic [14:0]               tr_addr_o,
  input  wire logic [15:0]          tr_data_i,
  input  wire logic                 tr_ack_i
);

  typedef enum logic [4:0] {
    ST_IDLE,
    ST_UNL_MODE,
    ST_UNL_TRIG,
    ST_UNL_KEY,
    ST_UNL_POLL,
    ST_ADDR_L,
    ST_ADDR_H,
    ST_ERS_GO,
    ST_WR_MODE,
    ST_LOAD_L,
    ST_LOAD_H,
    ST_WR_GO,
    ST_INIT_POLL,
    ST_VERIFY,
    ST_CLR_GO,
    ST_CLR_POLL,
    ST_DIS,
    ST_DONE
  } fiw_state_type;

  // Reset release through two flops
  logic rst_q1;
  logic rst_n;

  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      rst_q1 <= 1'b0;
      rst_n  <= 1'b0;
    end else begin
      rst_q1 <= 1'b1;
      rst_n  <= rst_q1;
    end
  end

  fiw_state_type state;
  fiw_state_type next_state;
  logic [5:0]    idx;
  logic [5:0]    next_idx;
  logic [2:0]    tries;
  logic [2:0]    next_tries;
  logic          writing;
  logic          next_writing;
  logic          is_write;
  logic [8:0]    page;
  logic [5:0]    last;
  logic          op_req;
  logic          op_pend;
  logic          op_done;
  logic [7:0]    op_rdata;
  logic [15:0]   store_word;
  logic          next_fail;
  logic          next_en;

  fiw_pkg::fiw_reg_op_type op;

  // Control register image; enable bit kept at one in erase and write steps since writing one is harmless, zero in unlock and disable steps
  function automatic logic [7:0] ctrl_val(input logic en, input logic [2:0] mode,
                                          input logic trig, input logic init);
    ctrl_val = {en, mode, trig, init, 2'b00};
  endfunction

  // Decoded conditions
  wire accept    = (state == ST_IDLE) && cmd_valid_i;
  wire [5:0] fin = writing ? last : fiw_pkg::PAGE_LAST;
  wire [15:0] expect_word = writing ? store_word : fiw_pkg::ERASED_VAL;
  wire word_bad  = tr_data_i != expect_word;
  wire out_of_tries = tries == fiw_pkg::RETRY_MAX;
  wire trig_busy = op_rdata[fiw_pkg::CTRL_TRIG_BIT];
  wire init_busy = op_rdata[fiw_pkg::CTRL_INIT_BIT];
  wire clr_busy  = op_rdata[fiw_pkg::BUF_CLR_BIT];
  wire en_seen   = op_rdata[fiw_pkg::CTRL_EN_BIT];
  wire op_state  = (state != ST_IDLE) && (state != ST_VERIFY) && (state != ST_DONE);
  wire [14:0] page_base = {page, 6'h00};

  // Register access for the current step
  always_comb begin
    op.read  = 1'b0;
    op.addr  = fiw_pkg::REG_CTRL;
    op.wdata = fiw_pkg::REG_RESET;
    case (state)
      ST_UNL_MODE: begin
        op.wdata = ctrl_val(1'b0, fiw_pkg::MODE_UNLOCK, 1'b0, 1'b0);
      end
      ST_UNL_TRIG: begin
        op.wdata = ctrl_val(1'b0, fiw_pkg::MODE_UNLOCK, 1'b1, 1'b0);
      end
      ST_UNL_KEY: begin
        // Low bytes first, then high bytes, all inside the window
        op.addr  = fiw_pkg::KEY_REG_SEQ[idx[2:0]*4 +: 4];
        op.wdata = fiw_pkg::KEY_BYTE_SEQ[idx[2:0]*8 +: 8];
      end
      ST_UNL_POLL, ST_INIT_POLL: begin
        op.read = 1'b1;
      end
      ST_ADDR_L: begin
        op.addr  = fiw_pkg::REG_ADDR_LO;
        op.wdata = page_base[7:0];
      end
      ST_ADDR_H: begin
        op.addr  = fiw_pkg::REG_ADDR_HI;
        op.wdata = {1'b0, page_base[14:8]};
      end
      ST_ERS_GO: begin
        op.wdata = ctrl_val(1'b1, fiw_pkg::MODE_ERASE, 1'b0, 1'b1);
      end
      ST_WR_MODE: begin
        op.wdata = ctrl_val(1'b1, fiw_pkg::MODE_WRITE, 1'b0, 1'b0);
      end
      ST_LOAD_L: begin
        op.addr  = fiw_pkg::REG_WD_LO;
        op.wdata = store_word[7:0];
      end
      ST_LOAD_H: begin
        op.addr  = fiw_pkg::REG_WD_HI;
        op.wdata = store_word[15:8];
      end
      ST_WR_GO: begin
        op.wdata = ctrl_val(1'b1, fiw_pkg::MODE_WRITE, 1'b0, 1'b1);
      end
      ST_CLR_GO: begin
        op.addr  = fiw_pkg::REG_BUFCTL;
        op.wdata = 8'h01 << fiw_pkg::BUF_CLR_BIT;
      end
      ST_CLR_POLL: begin
        op.read = 1'b1;
        op.addr = fiw_pkg::REG_BUFCTL;
      end
      ST_DIS: begin
        op.wdata = ctrl_val(1'b0, fiw_pkg::MODE_WRITE, 1'b0, 1'b0);
      end
      default: begin
        op.read = 1'b0;
      end
    endcase
  end

  // Sequencer
  always_comb begin
    next_state   = state;
    next_idx     = idx;
    next_tries   = tries;
    next_writing = writing;
    next_fail    = fail_o;
    next_en      = enabled_o;
    case (state)
      ST_IDLE: begin
        if (accept) begin
          next_idx     = 6'h00;
          next_tries   = 3'h0;
          next_writing = 1'b0;
          next_fail    = 1'b0;
          case (cmd_code_i)
            fiw_pkg::CMD_UNLOCK:  next_state = ST_UNL_MODE;
            fiw_pkg::CMD_DISABLE: next_state = ST_DIS;
            default:              next_state = ST_ADDR_L;
          endcase
        end
      end
      ST_UNL_MODE: if (op_done) next_state = ST_UNL_TRIG;
      ST_UNL_TRIG: if (op_done) next_state = ST_UNL_KEY;
      ST_UNL_KEY: begin
        if (op_done) begin
          next_idx = idx + 6'h01;
          if (idx[2:0] == fiw_pkg::KEY_LAST) begin
            next_idx   = 6'h00;
            next_state = ST_UNL_POLL;
          end
        end
      end
      ST_UNL_POLL: begin
        // Trigger drops when the window closes; only then is the key judged
        if (op_done && !trig_busy) begin
          if (en_seen) begin
            next_en    = 1'b1;
            next_state = ST_DONE;
          end else if (out_of_tries) begin
            next_fail  = 1'b1;
            next_state = ST_DONE;
          end else begin
            next_tries = tries + 3'h1;
            next_state = ST_UNL_MODE;
          end
        end
      end
      ST_ADDR_L: if (op_done) next_state = ST_ADDR_H;
      ST_ADDR_H: begin
        if (op_done) begin
          next_idx   = 6'h00;
          next_state = writing ? ST_LOAD_L : ST_ERS_GO;
        end
      end
      ST_ERS_GO: if (op_done) next_state = ST_INIT_POLL;
      ST_WR_MODE: if (op_done) next_state = ST_ADDR_L;
      ST_LOAD_L: if (op_done) next_state = ST_LOAD_H;
      ST_LOAD_H: begin
        if (op_done) begin
          // Never more than the page; the device would pin at its last word
          if (idx == last) begin
            next_idx   = 6'h00;
            next_state = ST_WR_GO;
          end else begin
            next_idx   = idx + 6'h01;
            next_state = ST_LOAD_L;
          end
        end
      end
      ST_WR_GO: if (op_done) next_state = ST_INIT_POLL;
      ST_INIT_POLL: begin
        // Reads stall while the processor is held, so each poll may take long
        if (op_done && !init_busy) begin
          next_idx   = 6'h00;
          next_state = ST_VERIFY;
        end
      end
      ST_VERIFY: begin
        if (tr_ack_i) begin
          if (word_bad && out_of_tries) begin
            next_fail  = 1'b1;
            next_state = ST_DONE;
          end else if (word_bad) begin
            next_tries = tries + 3'h1;
            next_state = writing ? ST_CLR_GO : ST_ADDR_L;
          end else if (idx == fin) begin
            next_tries   = 3'h0;
            next_writing = 1'b1;
            next_state   = (is_write && !writing) ? ST_WR_MODE : ST_DONE;
          end else begin
            next_idx = idx + 6'h01;
          end
        end
      end
      ST_CLR_GO: if (op_done) next_state = ST_CLR_POLL;
      ST_CLR_POLL: begin
        // Rewrite the same page with no erase once the buffer is empty
        if (op_done && !clr_busy) next_state = ST_ADDR_L;
      end
      ST_DIS: begin
        if (op_done) begin
          next_en    = 1'b0;
          next_state = ST_DONE;
        end
      end
      ST_DONE: next_state = ST_IDLE;
      default: next_state = ST_IDLE;
    endcase
  end

  // State registers
  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      state     <= ST_IDLE;
      idx       <= 6'h00;
      tries     <= 3'h0;
      writing   <= 1'b0;
      fail_o    <= 1'b0;
      enabled_o <= 1'b0;
    end else begin
      state     <= next_state;
      idx       <= next_idx;
      tries     <= next_tries;
      writing   <= next_writing;
      fail_o    <= next_fail;
      enabled_o <= next_en;
    end
  end

  // Command latch; a count of 0 or 64 both mean a full page
  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      page     <= 9'h000;
      last     <= fiw_pkg::PAGE_LAST;
      is_write <= 1'b0;
    end else if (accept) begin
      page     <= cmd_page_i;
      last     <= 6'(cmd_count_i - 7'h01);
      is_write <= cmd_code_i == fiw_pkg::CMD_WRITE;
    end
  end

  // Handshake flags and status outputs
  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      op_req      <= 1'b0;
      op_pend     <= 1'b0;
      tr_req_o    <= 1'b0;
      tr_addr_o   <= 15'h0000;
      cmd_ready_o <= 1'b0;
      done_o      <= 1'b0;
    end else begin
      op_req      <= op_state && !op_pend && !op_req;
      op_pend     <= op_req || (op_pend && !op_done);
      tr_req_o    <= (state == ST_VERIFY) && !tr_ack_i;
      tr_addr_o   <= page_base | {9'h000, idx};
      cmd_ready_o <= next_state == ST_IDLE;
      done_o      <= state == ST_DONE;
    end
  end

  fiw_page_store u_store (
    .clk_i   (clk_i),
    .we_i    (load_we_i),
    .widx_i  (load_idx_i),
    .wdata_i (load_data_i),
    .ridx_i  (idx),
    .rdata_o (store_word)
  );

  fiw_reg_port u_port (
    .clk_i       (clk_i),
    .rst_n_i     (rst_n),
    .req_i       (op_req),
    .op_i        (op),
    .done_o      (op_done),
    .rdata_o     (op_rdata),
    .dev_addr_o  (dev_addr_o),
    .dev_wdata_o (dev_wdata_o),
    .dev_wr_o    (dev_wr_o),
    .dev_rd_o    (dev_rd_o),
    .dev_rdata_i (dev_rdata_i),
    .dev_ack_i   (dev_ack_i)
  );

endmodule

// ### rtl/fiw_page_store.sv
// Local copy of one page of write data, kept for reload after a failed check
`timescale 1ns/1ps
module fiw_page_store (
  // Clock
  input  wire logic        clk_i,
  // Load port
  input  wire logic        we_i,
  input  wire logic [5:0]  widx_i,
  input  wire logic [15:0] wdata_i,
  // Read port
  input  wire logic [5:0]  ridx_i,
  output logic      [15:0] rdata_o
);

  logic [15:0] mem [64];

  // No reset: contents are defined by the user before any write command
  always_ff @(posedge clk_i) begin
    if (we_i) begin
      mem[widx_i] <= wdata_i;
    end
  end

  assign rdata_o = mem[ridx_i];

endmodule

// ### rtl/fiw_pkg.sv
// Constants and types shared by the flash update controller
package fiw_pkg;

  // Device register indices
  localparam logic [3:0] REG_CTRL    = 4'h0;
  localparam logic [3:0] REG_BUFCTL  = 4'h1;
  localparam logic [3:0] REG_ADDR_LO = 4'h2;
  localparam logic [3:0] REG_ADDR_HI = 4'h3;
  localparam logic [3:0] REG_WD_LO   = 4'h4;
  localparam logic [3:0] REG_WD_HI   = 4'h5;
  localparam logic [3:0] REG_K1_LO   = 4'h6;
  localparam logic [3:0] REG_K1_HI   = 4'h7;
  localparam logic [3:0] REG_K2_LO   = 4'h8;
  localparam logic [3:0] REG_K2_HI   = 4'h9;
  localparam logic [3:0] REG_K3_LO   = 4'ha;
  localparam logic [3:0] REG_K3_HI   = 4'hb;

  // Control and buffer control register field positions
  localparam int CTRL_EN_BIT   = 7;
  localparam int CTRL_MODE_LSB = 4;
  localparam int CTRL_TRIG_BIT = 3;
  localparam int CTRL_INIT_BIT = 2;
  localparam int BUF_CLR_BIT   = 0;

  // Operation mode codes
  localparam logic [2:0] MODE_WRITE  = 3'h0;
  localparam logic [2:0] MODE_ERASE  = 3'h1;
  localparam logic [2:0] MODE_UNLOCK = 3'h6;

  // Key sequence: register and byte for step 0 at the low end
  localparam logic [23:0] KEY_REG_SEQ = {REG_K3_HI, REG_K2_HI, REG_K1_HI,
                                         REG_K3_LO, REG_K2_LO, REG_K1_LO};
  localparam logic [47:0] KEY_BYTE_SEQ = 48'h40_09_04_c3_0d_00;
  localparam logic [2:0]  KEY_LAST     = 3'h5;

  // Page geometry, erased value, retry limit and register reset value
  localparam logic [5:0]  PAGE_LAST  = 6'h3f;
  localparam logic [15:0] ERASED_VAL = 16'h0000;
  localparam logic [2:0]  RETRY_MAX  = 3'h4;
  localparam logic [7:0]  REG_RESET  = 8'h00;

  // User commands
  typedef enum logic [1:0] {
    CMD_UNLOCK,
    CMD_ERASE,
    CMD_WRITE,
    CMD_DISABLE
  } fiw_cmd_type;

  // One device register access
  typedef struct packed {
    logic       read;
    logic [3:0] addr;
    logic [7:0] wdata;
  } fiw_reg_op_type;

endpackage

// ### rtl/fiw_reg_port.sv
// Single-access engine for the device register interface
`timescale 1ns/1ps
module fiw_reg_port (
  // Clock and reset
  input  wire logic                    clk_i,
  input  wire logic                    rst_n_i,
  // Request side
  input  wire logic                    req_i,
  input  wire fiw_pkg::fiw_reg_op_type op_i,
  output logic                         done_o,
  output logic [7:0]                   rdata_o,
  // Device register pins
  output logic [3:0]                   dev_addr_o,
  output logic [7:0]                   dev_wdata_o,
  output logic                         dev_wr_o,
  output logic                         dev_rd_o,
  input  wire logic [7:0]              dev_rdata_i,
  input  wire logic                    dev_ack_i
);

  logic busy;
  wire  start  = req_i && !busy;
  wire  finish = busy && dev_ack_i;

  // Strobe held until the device acknowledges; a stalled device just delays it
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      busy        <= 1'b0;
      done_o      <= 1'b0;
      rdata_o     <= fiw_pkg::REG_RESET;
      dev_addr_o  <= 4'h0;
      dev_wdata_o <= fiw_pkg::REG_RESET;
      dev_wr_o    <= 1'b0;
      dev_rd_o    <= 1'b0;
    end else begin
      done_o <= finish;
      if (start) begin
        busy        <= 1'b1;
        dev_addr_o  <= op_i.addr;
        dev_wdata_o <= op_i.wdata;
        dev_wr_o    <= !op_i.read;
        dev_rd_o    <= op_i.read;
      end else if (finish) begin
        busy     <= 1'b0;
        dev_wr_o <= 1'b0;
        dev_rd_o <= 1'b0;
        rdata_o  <= dev_rdata_i;
      end
    end
  end

endmodule

// ### tb/fiw_ctrl_props.sv
// Port-level assertions for the flash update controller
`timescale 1ns/1ps
module fiw_ctrl_props (
  // Clock and reset
  input wire logic                 clk_i,
  input wire logic                 reset_n_i,
  // User command
  input wire logic                 cmd_valid_i,
  input wire fiw_pkg::fiw_cmd_type cmd_code_i,
  input wire logic                 cmd_ready_o,
  // Device registers
  input wire logic [3:0]           dev_addr_o,
  input wire logic [7:0]           dev_wdata_o,
  input wire logic                 dev_wr_o,
  input wire logic                 dev_rd_o,
  input wire logic                 dev_ack_i,
  // Flash table read
  input wire logic                 tr_req_o,
  input wire logic [14:0]          tr_addr_o,
  input wire logic                 tr_ack_i
);
  logic [3:0] last_wr;
  logic [7:0] pg_lo;
  logic [7:0] pg_hi;
  // Decodes of the access on the register pins
  wire [15:0] pg     = {pg_hi, pg_lo};
  wire        ctl_wr = dev_wr_o && dev_addr_o == fiw_pkg::REG_CTRL;
  wire        strobe = dev_wr_o || dev_rd_o;
  wire [7:0]  lo_exp = dev_addr_o == fiw_pkg::REG_K1_LO ? 8'h00 :
                       dev_addr_o == fiw_pkg::REG_K2_LO ? 8'h0d : 8'hc3;
  wire [7:0]  hi_exp = dev_addr_o == fiw_pkg::REG_K1_HI ? 8'h04 :
                       dev_addr_o == fiw_pkg::REG_K2_HI ? 8'h09 : 8'h40;
  wire        k_lo   = dev_wr_o && dev_addr_o inside {fiw_pkg::REG_K1_LO, fiw_pkg::REG_K2_LO,
                       fiw_pkg::REG_K3_LO};
  wire        k_hi   = dev_wr_o && dev_addr_o inside {fiw_pkg::REG_K1_HI, fiw_pkg::REG_K2_HI,
                       fiw_pkg::REG_K3_HI};
  default clocking @(posedge clk_i);
  endclocking
  default disable iff (!reset_n_i);
  // Last completed write and the page it selected; reads are judged against it
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      last_wr <= 4'h0;
      pg_lo   <= 8'h00;
      pg_hi   <= 8'h00;
    end else if (dev_wr_o && dev_ack_i) begin
      last_wr <= dev_addr_o;
      if (dev_addr_o == fiw_pkg::REG_ADDR_LO) pg_lo <= dev_wdata_o;
      if (dev_addr_o == fiw_pkg::REG_ADDR_HI) pg_hi <= dev_wdata_o;
    end
  end
  AST_UNLOCK_MODE: assert property (ctl_wr && dev_wdata_o[3] |-> dev_wdata_o[6:4] == 3'h6)
    else $error("trigger written outside unlock mode");
  AST_KEY_LOW: assert property (k_lo |-> dev_wdata_o == lo_exp)
    else $error("wrong low key byte");
  AST_KEY_HIGH: assert property (k_hi |-> dev_wdata_o == hi_exp)
    else $error("wrong high key byte");
  AST_HI_AFTER_LO: assert property (dev_wr_o && dev_addr_o == fiw_pkg::REG_WD_HI |-> last_wr == fiw_pkg::REG_WD_LO)
    else $error("high data byte not preceded by low byte");
  AST_INIT_MODE: assert property (ctl_wr && dev_wdata_o[2] |-> !dev_wdata_o[3] && dev_wdata_o[6:4] inside {3'h0, 3'h1})
    else $error("initiate written with a bad mode");
  AST_STROBE_HOLD: assert property (strobe && !dev_ack_i |=> strobe && $stable(dev_wr_o) && $stable(dev_addr_o) && $stable(dev_wdata_o))
    else $error("access changed before acknowledge");
  AST_ONE_STROBE: assert property (!(dev_wr_o && dev_rd_o))
    else $error("read and write strobes together");
  AST_PAGE_READ: assert property (tr_req_o |-> tr_addr_o[14:6] == pg[14:6])
    else $error("table read outside the addressed page");
  AST_TR_DROP: assert property (tr_ack_i |=> !tr_req_o)
    else $error("table read held past acknowledge");
  AST_DISABLE_WRITE: assert property (cmd_valid_i && cmd_ready_o && cmd_code_i == fiw_pkg::CMD_DISABLE |-> ##[1:40] (ctl_wr && !dev_wdata_o[7]))
    else $error("disable did not clear the enable bit");
  AST_BUF_CLEAR: assert property (dev_wr_o && dev_addr_o == fiw_pkg::REG_BUFCTL |-> dev_wdata_o == 8'h01)
    else $error("buffer control written with other bits");
endmodule
bind fiw_ctrl fiw_ctrl_props fiw_ctrl_props_i (.clk_i(clk_i), .reset_n_i(reset_n_i),
  .cmd_valid_i(cmd_valid_i), .cmd_code_i(cmd_code_i), .cmd_ready_o(cmd_ready_o),
  .dev_addr_o(dev_addr_o), .dev_wdata_o(dev_wdata_o), .dev_wr_o(dev_wr_o), .dev_rd_o(dev_rd_o),
  .dev_ack_i(dev_ack_i), .tr_req_o(tr_req_o), .tr_addr_o(tr_addr_o), .tr_ack_i(tr_ack_i));

// ### tb/fiw_ctrl_tb.sv
// Self-checking bench: controller against the device model
`timescale 1ns/1ps
`define CHK(got, exp) begin num_checks++; if ((got) !== (exp)) begin mismatches++; \
  $display("mismatch at %0t: got %h expected %h", $time, (got), (exp)); end end
module fiw_ctrl_tb;
  logic                 clk_i, reset_n_i, cmd_valid_i, load_we_i, dev_ack_i, tr_ack_i;
  logic                 cmd_ready_o, done_o, fail_o, enabled_o, dev_wr_o, dev_rd_o, tr_req_o;
  fiw_pkg::fiw_cmd_type cmd_code_i;
  logic [8:0]           cmd_page_i;
  logic [6:0]           cmd_count_i;
  logic [5:0]           load_idx_i;
  logic [15:0]          load_data_i, tr_data_i;
  logic [3:0]           dev_addr_o;
  logic [7:0]           dev_wdata_o, dev_rdata_i;
  logic [14:0]          tr_addr_o;
  int                   mismatches, num_checks, e0, p0, c0;
  fiw_ctrl fiw_ctrl_i (.clk_i(clk_i), .reset_n_i(reset_n_i), .cmd_valid_i(cmd_valid_i),
    .cmd_code_i(cmd_code_i), .cmd_page_i(cmd_page_i), .cmd_count_i(cmd_count_i),
    .cmd_ready_o(cmd_ready_o), .done_o(done_o), .fail_o(fail_o), .enabled_o(enabled_o),
    .load_we_i(load_we_i), .load_idx_i(load_idx_i), .load_data_i(load_data_i),
    .dev_addr_o(dev_addr_o), .dev_wdata_o(dev_wdata_o), .dev_wr_o(dev_wr_o), .dev_rd_o(dev_rd_o),
    .dev_rdata_i(dev_rdata_i), .dev_ack_i(dev_ack_i), .tr_req_o(tr_req_o),
    .tr_addr_o(tr_addr_o), .tr_data_i(tr_data_i), .tr_ack_i(tr_ack_i));
  fiw_dev_model fiw_dev_model_i (.clk_i(clk_i), .reset_n_i(reset_n_i), .dev_addr_i(dev_addr_o),
    .dev_wdata_i(dev_wdata_o), .dev_wr_i(dev_wr_o), .dev_rd_i(dev_rd_o),
    .dev_rdata_o(dev_rdata_i), .dev_ack_o(dev_ack_i), .tr_req_i(tr_req_o),
    .tr_addr_i(tr_addr_o), .tr_data_o(tr_data_i), .tr_ack_o(tr_ack_i));
  // 200 MHz clock
  initial begin
    clk_i = 1'b0;
    forever #2.5 clk_i = ~clk_i;
  end
  function automatic logic [15:0] pat(input logic [5:0] i);
    return {8'ha5, 2'b00, i};
  endfunction
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  // One command: wait for ready, hold valid over the taking edge, wait for done
  task automatic run_cmd(input fiw_pkg::fiw_cmd_type c, input logic [8:0] p, input logic [6:0] n);
    int k;
    for (k = 0; k < 100 && cmd_ready_o !== 1'b1; k++) @(posedge clk_i) #1;
    {cmd_valid_i, cmd_page_i, cmd_count_i} = {1'b1, p, n};
    cmd_code_i = c;
    @(posedge clk_i) #1;
    cmd_valid_i = 1'b0;
    for (k = 0; k < 20000 && done_o !== 1'b1; k++) @(posedge clk_i) #1;
    `CHK(done_o, 1'b1)
  endtask
  task automatic check_page(input logic [8:0] p, input int n);
    for (int i = 0; i < 64; i++) `CHK(fiw_dev_model_i.mem[{p, i[5:0]}], i < n ? pat(i[5:0]) : 16'h0000)
  endtask
  task automatic t_locked_erase();
    run_cmd(fiw_pkg::CMD_ERASE, 9'h005, 7'h00);
    `CHK(fail_o, 1'b1)
    `CHK(fiw_dev_model_i.mem[15'h0140], 16'hffff)
  endtask
  task automatic t_unlock();
    fiw_dev_model_i.key_faults <= 9;
    run_cmd(fiw_pkg::CMD_UNLOCK, 9'h000, 7'h00);
    `CHK({fail_o, enabled_o, fiw_dev_model_i.ctrl[7]}, 3'h4)
    fiw_dev_model_i.key_faults <= 1;
    run_cmd(fiw_pkg::CMD_UNLOCK, 9'h000, 7'h00);
    `CHK({fail_o, enabled_o, fiw_dev_model_i.ctrl[7]}, 3'h3)
    `CHK(fiw_dev_model_i.ctrl[3], 1'b0)
  endtask
  task automatic t_write_full();
    for (int i = 0; i < 64; i++) begin
      {load_we_i, load_idx_i, load_data_i} = {1'b1, i[5:0], pat(i[5:0])};
      @(posedge clk_i) #1;
    end
    load_we_i = 1'b0;
    run_cmd(fiw_pkg::CMD_WRITE, 9'h0a3, 7'h00);
    `CHK(fail_o, 1'b0)
    check_page(9'h0a3, 64);
    `CHK(fiw_dev_model_i.ptr, 6'h3f)
    `CHK(fiw_dev_model_i.ctrl[2], 1'b0)
  endtask
  // Slow device, one bad erase and one bad program on the same command
  task automatic t_write_retry();
    {e0, p0, c0} = {fiw_dev_model_i.n_erase, fiw_dev_model_i.n_prog, fiw_dev_model_i.n_clr};
    {fiw_dev_model_i.lat, fiw_dev_model_i.erase_faults, fiw_dev_model_i.write_faults} <= {32'd2, 32'd1, 32'd1};
    run_cmd(fiw_pkg::CMD_WRITE, 9'h011, 7'h03);
    `CHK(fail_o, 1'b0)
    check_page(9'h011, 3);
    `CHK(fiw_dev_model_i.n_erase - e0, 2)
    `CHK(fiw_dev_model_i.n_prog - p0, 2)
    `CHK(fiw_dev_model_i.n_clr - c0, 1)
    `CHK(fiw_dev_model_i.bufctl[0], 1'b0)
  endtask
  task automatic t_disable();
    run_cmd(fiw_pkg::CMD_DISABLE, 9'h000, 7'h00);
    `CHK({enabled_o, fiw_dev_model_i.ctrl[7]}, 2'h0)
    run_cmd(fiw_pkg::CMD_ERASE, 9'h0a3, 7'h00);
    `CHK(fail_o, 1'b1)
    `CHK(fiw_dev_model_i.mem[{9'h0a3, 6'h05}], pat(6'h05))
  endtask
  // Watchdog well beyond the expected run of some 3500 cycles
  initial begin
    #400000;
    mismatches++;
    tally_and_finish();
  end
  initial begin
    {reset_n_i, cmd_valid_i, cmd_page_i, cmd_count_i, load_we_i, load_idx_i, load_data_i} = '0;
    cmd_code_i = fiw_pkg::CMD_UNLOCK;
    {mismatches, num_checks} = '0;
    repeat (16) @(posedge clk_i);
    #1;
    `CHK({cmd_ready_o, dev_wr_o, dev_rd_o, tr_req_o}, 4'h0)
    reset_n_i = 1'b1;
    t_locked_erase();
    t_unlock();
    t_write_full();
    t_write_retry();
    t_disable();
    tally_and_finish();
  end
endmodule

// ### tb/fiw_dev_model.sv
// Behavioural device: update registers, write buffer, flash array
`timescale 1ns/1ps
module fiw_dev_model #(
  parameter int WIN_CYC = 200,
  parameter int OP_CYC  = 24
) (
  // Clock and reset
  input  wire logic        clk_i,
  input  wire logic        reset_n_i,
  // Register access
  input  wire logic [3:0]  dev_addr_i,
  input  wire logic [7:0]  dev_wdata_i,
  input  wire logic        dev_wr_i,
  input  wire logic        dev_rd_i,
  output logic      [7:0]  dev_rdata_o,
  output logic             dev_ack_o,
  // Table read
  input  wire logic        tr_req_i,
  input  wire logic [14:0] tr_addr_i,
  output logic      [15:0] tr_data_o,
  output logic             tr_ack_o
);
  logic [7:0]  ctrl, bufctl, alo, ahi, wlo;
  logic [7:0]  kreg [0:5];
  logic [15:0] mem [0:32767];
  logic [15:0] wbuf [0:63];
  logic [5:0]  ptr;
  int          lat, wcnt, win, opc, clrc, j;
  int          key_faults, erase_faults, write_faults, n_erase, n_prog, n_clr;
  // Page select, key match and read decode
  wire  [15:0] addr_w = {ahi, alo};
  wire  [8:0]  page   = addr_w[14:6];
  wire         is_er  = ctrl[6:4] == 3'h1;
  wire         key_ok = {kreg[0], kreg[2], kreg[4]} == 24'h000dc3 &&
                        {kreg[1], kreg[3], kreg[5]} == 24'h040940;
  wire  [7:0]  rd_val = dev_addr_i == fiw_pkg::REG_CTRL ? ctrl : bufctl;
  // Flash starts non-blank so a skipped erase shows up
  initial begin
    for (int i = 0; i < 32768; i++) mem[i] <= 16'hffff;
    {lat, key_faults, erase_faults, write_faults, n_erase, n_prog, n_clr} <= '0;
  end
  // Released buses show the inverse of their last value, never a stale copy
  always @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      {ctrl, bufctl, alo, ahi, wlo, ptr, dev_rdata_o, dev_ack_o, tr_data_o, tr_ack_o} <= '0;
      {wcnt, win, opc, clrc} <= '0;
    end else begin
      dev_ack_o <= 1'b0;
      dev_rdata_o <= ~dev_rdata_o;
      tr_ack_o <= tr_req_i && !tr_ack_o;
      tr_data_o <= (tr_req_i && !tr_ack_o) ? mem[tr_addr_i] : ~tr_data_o;
      if (win > 0) win <= win - 1;
      if (win == 1) begin
        ctrl[3] <= 1'b0;
        if (key_ok && key_faults == 0) ctrl[7] <= 1'b1;
        if (key_faults > 0) key_faults <= key_faults - 1;
      end
      if (clrc > 0) clrc <= clrc - 1;
      if (clrc == 1) bufctl[0] <= 1'b0;
      if (opc > 0) opc <= opc - 1;
      if (opc == 1) begin
        ctrl[2] <= 1'b0;
        n_erase <= n_erase + int'(is_er);
        n_prog <= n_prog + int'(!is_er);
        if (is_er && erase_faults > 0) erase_faults <= erase_faults - 1;
        if (!is_er && write_faults > 0) write_faults <= write_faults - 1;
        // Programming only sets bits; a cleared buffer word leaves flash as it is
        for (j = 0; j < 64; j++) begin
          if (is_er) mem[{page, j[5:0]}] <= (j == 0 && erase_faults > 0) ? 16'h0001 : 16'h0000;
          else if (j != 0 || write_faults == 0) mem[{page, j[5:0]}] <= mem[{page, j[5:0]}] | wbuf[j];
          if (!is_er || clrc == 1) wbuf[j] <= 16'h0000;
        end
      end else if (clrc == 1) begin
        for (j = 0; j < 64; j++) wbuf[j] <= 16'h0000;
      end
      // No access is answered while an operation runs: the processor is stalled
      if ((dev_wr_i || dev_rd_i) && !dev_ack_o && opc == 0) begin
        wcnt <= (wcnt < lat) ? wcnt + 1 : 0;
        if (wcnt >= lat) dev_ack_o <= 1'b1;
        if (wcnt >= lat && dev_rd_i) dev_rdata_o <= rd_val;
        if (wcnt >= lat && dev_wr_i) begin
          case (dev_addr_i)
            fiw_pkg::REG_CTRL: begin
              ctrl[7] <= ctrl[7] & dev_wdata_i[7];
              ctrl[6:4] <= dev_wdata_i[6:4];
              if (dev_wdata_i[3] && dev_wdata_i[6:4] == 3'h6) ctrl[3] <= 1'b1;
              if (dev_wdata_i[3] && dev_wdata_i[6:4] == 3'h6) win <= WIN_CYC;
              if (dev_wdata_i[2] && ctrl[7] && dev_wdata_i[6:4] < 3'h2) ctrl[2] <= 1'b1;
              if (dev_wdata_i[2] && ctrl[7] && dev_wdata_i[6:4] < 3'h2) opc <= OP_CYC;
            end
            fiw_pkg::REG_BUFCTL: if (dev_wdata_i[0]) {bufctl[0], clrc, n_clr} <= {1'b1, 32'd4, n_clr + 1};
            fiw_pkg::REG_ADDR_LO: {alo, ptr} <= {dev_wdata_i, dev_wdata_i[5:0]};
            fiw_pkg::REG_ADDR_HI: ahi <= dev_wdata_i;
            fiw_pkg::REG_WD_LO: wlo <= dev_wdata_i;
            fiw_pkg::REG_WD_HI: begin
              wbuf[ptr] <= {dev_wdata_i, wlo};
              if (ptr != 6'h3f) ptr <= ptr + 6'h01;
            end
            default: kreg[dev_addr_i - 4'h6] <= dev_wdata_i;
          endcase
        end
      end
    end
  end
endmodule
